//--- ivd_pkg.sv
// package: interrupt vector dispatch constants and types
`default_nettype none
package ivd_pkg;
  localparam int unsigned IVD_NSRC   = 17;
  localparam int unsigned IVD_IDX_W  = 5;
  localparam logic [15:0] IVD_VEC_BASE = 16'h0003;
  localparam int unsigned IVD_VEC_STEP = 8;
  localparam logic [15:0] IVD_VEC_RESET = 16'h0000;
  localparam logic [4:0]  IVD_RESERVED_ORDER = 5'h0d;
  // register offsets
  localparam logic [7:0] IVD_OFS_INT_EN    = 8'ha8;
  localparam logic [7:0] IVD_OFS_INT_PRI   = 8'hb8;
  localparam logic [7:0] IVD_OFS_MORE_PRI1 = 8'hce;
  localparam logic [7:0] IVD_OFS_MORE_PRI2 = 8'hcf;
  localparam logic [7:0] IVD_OFS_MORE_EN1  = 8'he6;
  localparam logic [7:0] IVD_OFS_MORE_EN2  = 8'he7;
  localparam logic [7:0] IVD_OFS_STAT = 8'hf0;
  localparam logic [7:0] IVD_OFS_MASK = 8'hf1;
  localparam logic [7:0] IVD_OFS_CUR  = 8'hf2;
  localparam logic [7:0] IVD_RST_REG  = 8'h00;
  // flag bit positions
  localparam int unsigned IVD_EXT0_PEND = 1;
  localparam int unsigned IVD_TMR0_OVF  = 5;
  localparam int unsigned IVD_EXT1_PEND = 3;
  localparam int unsigned IVD_TMR1_OVF  = 7;
  localparam int unsigned IVD_SPI_LSB   = 4;
  localparam int unsigned IVD_PCA_MATCH_TOP = 6;
  localparam int unsigned IVD_UART_RX  = 0;
  localparam int unsigned IVD_UART_TX  = 1;
  localparam int unsigned IVD_TMR_HI   = 7;
  localparam int unsigned IVD_TMR_LO   = 6;
  localparam int unsigned IVD_SMB_EV   = 0;
  localparam int unsigned IVD_ADC_WIN  = 3;
  localparam int unsigned IVD_ADC_DONE = 5;
  localparam int unsigned IVD_PCA_OVF  = 7;
  localparam int unsigned IVD_CMP_FALL = 4;
  localparam int unsigned IVD_CMP_RISE = 5;
  localparam int unsigned IVD_TS_DONE  = 5;
  localparam int unsigned IVD_TS_ABOVE = 0;
  // host status event bits
  localparam int unsigned IVD_EV_TAKEN = 0;
  localparam int unsigned IVD_EV_HIGH  = 1;
  typedef enum logic [1:0] {IVD_IDLE, IVD_ACK, IVD_RUN} ivd_host_state_e;
endpackage : ivd_pkg
`default_nettype wire

//--- ivd_if.sv
// interface joining the dispatcher and the core side
`default_nettype none
interface ivd_if;
  logic [7:0]  timer_control_reg;
  logic [7:0]  uart_control_reg;
  logic [7:0]  timer2_control_reg;
  logic [7:0]  timer3_control_reg;
  logic [7:0]  spi_control_reg;
  logic [7:0]  smbus_control_reg;
  logic [7:0]  adc_control_reg;
  logic [7:0]  pca_control_reg;
  logic [7:0]  comparator_control_reg;
  logic [7:0]  touch_sense_control_reg;
  logic        port_match;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        irq_req;
  logic [15:0] irq_vector;
  logic [4:0]  irq_order;
  logic        irq_high;
  logic        irq_ack;
  logic        ext0_clear;
  logic        tmr0_clear;
  logic        ext1_clear;
  logic        tmr1_clear;
  modport dev (input timer_control_reg, uart_control_reg, timer2_control_reg, timer3_control_reg,
    spi_control_reg, smbus_control_reg, adc_control_reg, pca_control_reg, comparator_control_reg,
    touch_sense_control_reg, port_match, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack,
    output sfr_rdata, irq_req, irq_vector, irq_order, irq_high, ext0_clear, tmr0_clear,
    ext1_clear, tmr1_clear);
  modport core (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack,
    input sfr_rdata, irq_req, irq_vector, irq_order, irq_high);
endinterface : ivd_if
`default_nettype wire

//--- ivd_dispatch.sv
// device end: interrupt source table, enables, priorities and vector choice
// Function
// - reset is top vector, never masked
// - ext_irq_0 vector 0x0003, hardware cleared
// - timer 0 overflow 0x000B, hardware cleared
// - ext_irq_1 vector 0x0013, hardware cleared
// - timer 1 overflow 0x001B, hardware cleared
// - uart flags vector 0x0023, software clears
// - timer 2 flags vector 0x002B, software clears
// - any spi flag vectors 0x0033
// - smbus event vector 0x003B, software clears
// - port match vector 0x0043, no flag
// - adc window hit vector 0x004B
// - adc conversion done vector 0x0053
// - counter array flags vector 0x005B
// - comparator edge flags vector 0x0063
// - timer 3 flags vector 0x0073
// - touch-sense done vector 0x007B
// - touch-sense above threshold vector 0x0083
//
// Local design decision: the plain strobed port.
`default_nettype none
module ivd_dispatch
  import ivd_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  ivd_if.dev        bus
);
  logic [7:0] interrupt_enable_ff;
  logic [7:0] interrupt_priority_ff;
  logic [7:0] more_irq_enable_1_ff;
  logic [7:0] more_irq_enable_2_ff;
  logic [7:0] more_irq_priority_1_ff;
  logic [7:0] more_irq_priority_2_ff;
  logic [7:0] sfr_rdata_ff;
  logic [IVD_NSRC-1:0] pend;
  logic [IVD_NSRC-1:0] en;
  logic [IVD_NSRC-1:0] pri;
  logic [IVD_NSRC-1:0] req;
  logic        nxt_req;
  logic [4:0]  nxt_order;
  logic        nxt_high;
  logic        irq_req_ff;
  logic [4:0]  irq_order_ff;
  logic        irq_high_ff;
  logic [15:0] irq_vector_ff;

  // vector is base plus eight per order
  function automatic logic [15:0] order_vec(input logic [4:0] ord);
    order_vec = IVD_VEC_BASE + {8'h00, ord, 3'b000};
  endfunction

  // the reserved slot reads as constant zero, so writing its bit is harmless
  function automatic logic [IVD_NSRC-1:0] by_order(
    input logic [7:0] base_byte,
    input logic [7:0] more_1_byte,
    input logic [7:0] more_2_byte
  );
    by_order = {more_2_byte[1:0], more_1_byte[7], 1'b0, more_1_byte[5:0], base_byte[6:0]};
  endfunction

  // source pending flags, indexed by order
  always_comb begin
    pend = '0;
    pend[0] = bus.timer_control_reg[IVD_EXT0_PEND];
    pend[1] = bus.timer_control_reg[IVD_TMR0_OVF];
    pend[2] = bus.timer_control_reg[IVD_EXT1_PEND];
    pend[3] = bus.timer_control_reg[IVD_TMR1_OVF];
    pend[4] = bus.uart_control_reg[IVD_UART_RX] | bus.uart_control_reg[IVD_UART_TX];
    pend[5] = bus.timer2_control_reg[IVD_TMR_HI] | bus.timer2_control_reg[IVD_TMR_LO];
    pend[6] = |bus.spi_control_reg[7:IVD_SPI_LSB];
    pend[7] = bus.smbus_control_reg[IVD_SMB_EV];
    pend[8] = bus.port_match;
    pend[9] = bus.adc_control_reg[IVD_ADC_WIN];
    pend[10] = bus.adc_control_reg[IVD_ADC_DONE];
    pend[11] = bus.pca_control_reg[IVD_PCA_OVF] | (|bus.pca_control_reg[IVD_PCA_MATCH_TOP:0]);
    pend[12] = bus.comparator_control_reg[IVD_CMP_FALL] | bus.comparator_control_reg[IVD_CMP_RISE];
    pend[13] = 1'b0;
    pend[14] = bus.timer3_control_reg[IVD_TMR_HI] | bus.timer3_control_reg[IVD_TMR_LO];
    pend[15] = bus.touch_sense_control_reg[IVD_TS_DONE];
    pend[16] = bus.touch_sense_control_reg[IVD_TS_ABOVE];
  end

  assign en  = by_order(interrupt_enable_ff, more_irq_enable_1_ff, more_irq_enable_2_ff);
  assign pri = by_order(interrupt_priority_ff, more_irq_priority_1_ff, more_irq_priority_2_ff);

  for (genvar g = 0; g < IVD_NSRC; g++) begin : g_req
    assign req[g] = pend[g] & en[g];
  end

  // high level, lowest order wins
  // low pass picks a candidate, high pass may overwrite it
  always_comb begin
    nxt_req   = 1'b0;
    nxt_order = 5'h00;
    nxt_high  = 1'b0;
    for (int i = IVD_NSRC - 1; i >= 0; i--) begin
      if (req[i] && !pri[i] && !(nxt_req && nxt_high)) begin
        nxt_req   = 1'b1;
        nxt_order = 5'(i);
      end
    end
    for (int i = IVD_NSRC - 1; i >= 0; i--) begin
      if (req[i] && pri[i]) begin
        nxt_req   = 1'b1;
        nxt_order = 5'(i);
        nxt_high  = 1'b1;
      end
    end
  end

  // registered request toward the core
  // registered so vector, order and level always change together
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_ff    <= 1'b0;
      irq_order_ff  <= 5'h00;
      irq_high_ff   <= 1'b0;
      irq_vector_ff <= IVD_VEC_RESET;
    end else begin
      irq_req_ff    <= nxt_req;
      irq_order_ff  <= nxt_order;
      irq_high_ff   <= nxt_high;
      irq_vector_ff <= nxt_req ? order_vec(nxt_order) : IVD_VEC_RESET;
    end
  end

  // register writes
  // addresses outside this table are dropped here; the core end's own never reach this port
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_enable_ff    <= IVD_RST_REG;
      interrupt_priority_ff  <= IVD_RST_REG;
      more_irq_enable_1_ff   <= IVD_RST_REG;
      more_irq_enable_2_ff   <= IVD_RST_REG;
      more_irq_priority_1_ff <= IVD_RST_REG;
      more_irq_priority_2_ff <= IVD_RST_REG;
    end else if (bus.sfr_wr) begin
      case (bus.sfr_addr)
        IVD_OFS_INT_EN:    interrupt_enable_ff    <= bus.sfr_wdata;
        IVD_OFS_INT_PRI:   interrupt_priority_ff  <= bus.sfr_wdata;
        IVD_OFS_MORE_EN1:  more_irq_enable_1_ff   <= bus.sfr_wdata;
        IVD_OFS_MORE_EN2:  more_irq_enable_2_ff   <= bus.sfr_wdata;
        IVD_OFS_MORE_PRI1: more_irq_priority_1_ff <= bus.sfr_wdata;
        IVD_OFS_MORE_PRI2: more_irq_priority_2_ff <= bus.sfr_wdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata_ff <= 8'h00;
    end else if (bus.sfr_rd) begin
      case (bus.sfr_addr)
        IVD_OFS_INT_EN:    sfr_rdata_ff <= interrupt_enable_ff;
        IVD_OFS_INT_PRI:   sfr_rdata_ff <= interrupt_priority_ff;
        IVD_OFS_MORE_EN1:  sfr_rdata_ff <= more_irq_enable_1_ff;
        IVD_OFS_MORE_EN2:  sfr_rdata_ff <= more_irq_enable_2_ff;
        IVD_OFS_MORE_PRI1: sfr_rdata_ff <= more_irq_priority_1_ff;
        IVD_OFS_MORE_PRI2: sfr_rdata_ff <= more_irq_priority_2_ff;
        default:           sfr_rdata_ff <= 8'h00;
      endcase
    end else begin
      sfr_rdata_ff <= 8'h00;
    end
  end

  assign bus.sfr_rdata  = sfr_rdata_ff;
  assign bus.irq_req    = irq_req_ff;
  assign bus.irq_vector = irq_vector_ff;
  assign bus.irq_order  = irq_order_ff;
  assign bus.irq_high   = irq_high_ff;

  // hardware clears only the four timer-control flags on vectoring
  // ext0 cleared on ack
  assign bus.ext0_clear = bus.irq_ack && irq_req_ff && irq_order_ff == 5'd0;
  assign bus.tmr0_clear = bus.irq_ack && irq_req_ff && irq_order_ff == 5'd1;
  assign bus.ext1_clear = bus.irq_ack && irq_req_ff && irq_order_ff == 5'd2;
  assign bus.tmr1_clear = bus.irq_ack && irq_req_ff && irq_order_ff == 5'd3;
endmodule // ivd_dispatch
`default_nettype wire

//--- ivd_core_end.sv
// core end: register port bridge and vector acceptance with status/mask
`default_nettype none
module ivd_core_end
  import ivd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  ivd_if.core              bus,
  input  wire logic [7:0]  sw_addr,
  input  wire logic [7:0]  sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [7:0]  sw_rdata,
  input  wire logic        take_en,
  input  wire logic        reti,
  output logic             fetch,
  output logic      [15:0] fetch_vector,
  output logic             irq
);
  ivd_host_state_e state_ff;
  logic [7:0]  stat_ff;
  logic [7:0]  mask_ff;
  logic [15:0] vec_ff;
  logic [4:0]  cur_order_ff;
  logic        cur_high_ff;
  logic        rd_local_ff;
  logic [7:0]  rd_local_data_ff;
  logic        local_hit;
  logic        take;

  // own registers sit in a window the device leaves unused
  assign local_hit = (sw_addr == IVD_OFS_STAT) || (sw_addr == IVD_OFS_MASK) || (sw_addr == IVD_OFS_CUR);

  assign bus.sfr_wr    = sw_wr && !local_hit;
  assign bus.sfr_rd    = sw_rd && !local_hit;
  assign bus.sfr_addr  = sw_addr;
  assign bus.sfr_wdata = sw_wdata;

  // a running high-level service is preempted by nothing
  assign take = (state_ff == IVD_IDLE) && take_en && bus.irq_req ||
                (state_ff == IVD_RUN) && take_en && bus.irq_req && bus.irq_high && !cur_high_ff;
  assign bus.irq_ack = take;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= IVD_IDLE;
      vec_ff       <= IVD_VEC_RESET;
      cur_order_ff <= 5'h00;
      cur_high_ff  <= 1'b0;
    end else begin
      case (state_ff)
        IVD_IDLE: if (take) state_ff <= IVD_ACK;
        IVD_ACK:  state_ff <= IVD_RUN;
        IVD_RUN: begin
          if (take) state_ff <= IVD_ACK;
          else if (reti) state_ff <= IVD_IDLE;
        end
        default:  state_ff <= IVD_IDLE;
      endcase
      if (take) begin
        vec_ff       <= bus.irq_vector;
        cur_order_ff <= bus.irq_order;
        cur_high_ff  <= bus.irq_high;
      end
    end
  end

  assign fetch        = (state_ff == IVD_ACK);
  assign fetch_vector = vec_ff;

  // set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (take && ((i == IVD_EV_TAKEN) || (i == IVD_EV_HIGH && bus.irq_high)))
          stat_ff[i] <= 1'b1;
        else if (sw_wr && sw_addr == IVD_OFS_STAT && sw_wdata[i])
          stat_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) mask_ff <= 8'h00;
    else if (sw_wr && sw_addr == IVD_OFS_MASK) mask_ff <= sw_wdata;
  end

  assign irq = |(stat_ff & mask_ff);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_local_ff      <= 1'b0;
      rd_local_data_ff <= 8'h00;
    end else begin
      rd_local_ff <= sw_rd && local_hit;
      case (sw_addr)
        IVD_OFS_STAT: rd_local_data_ff <= stat_ff;
        IVD_OFS_MASK: rd_local_data_ff <= mask_ff;
        IVD_OFS_CUR:  rd_local_data_ff <= {cur_high_ff, 2'b00, cur_order_ff};
        default:      rd_local_data_ff <= 8'h00;
      endcase
    end
  end

  assign sw_rdata = rd_local_ff ? rd_local_data_ff : bus.sfr_rdata;
endmodule // ivd_core_end
`default_nettype wire

//--- ivd_props.sv
// checker: assertions on the dispatcher to core interface
`default_nettype none
module ivd_props
  import ivd_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  timer_control_reg,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [4:0]  irq_order,
  input wire logic        irq_ack,
  input wire logic        ext0_clear,
  input wire logic        tmr1_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] en_shadow_ff;
  // shadow of the enable register, as the bus writes it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      en_shadow_ff <= 8'h00;
    else if (sfr_wr && sfr_addr == IVD_OFS_INT_EN)
      en_shadow_ff <= sfr_wdata;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_vec_by_order: assert property (irq_req |-> irq_vector == IVD_VEC_BASE + 16'(irq_order) * 16'h0008)
    else $error("vector does not follow order");
  chk_idle_vec_zero: assert property (!irq_req |-> irq_vector == IVD_VEC_RESET)
    else $error("vector not zero while idle");
  chk_reserved_never: assert property (irq_req |-> irq_order != IVD_RESERVED_ORDER)
    else $error("reserved slot requested");
  chk_tmr0_req_next: assert property (timer_control_reg[IVD_TMR0_OVF] && en_shadow_ff[1] |=> irq_req)
    else $error("enabled timer 0 flag gave no request");
  chk_ext0_hw_clear: assert property (irq_ack && irq_req && irq_order == 5'h00 |-> ext0_clear)
    else $error("ext0 flag not cleared on ack");
  chk_tmr1_hw_clear: assert property (irq_ack && irq_req && irq_order == 5'h03 |-> tmr1_clear)
    else $error("timer 1 flag not cleared on ack");
  chk_ack_has_req: assert property (irq_ack |-> irq_req)
    else $error("ack without request");
  chk_rdata_quiet: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data outside read slot");
  cover property (irq_ack && irq_order == 5'h01);
  cover property (ext0_clear);
  cover property (sfr_rd ##1 sfr_rdata != 8'h00);
endmodule // ivd_props
`default_nettype wire

//--- tb_top.sv
// testbench: both ends joined, driven through the software port
`default_nettype none
module tb_top
  import ivd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk;
  logic        arst_n;
  logic [7:0]  sw_addr;
  logic [7:0]  sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [7:0]  sw_rdata;
  logic        take_en;
  logic        reti;
  logic        fetch;
  logic [15:0] fetch_vector;
  logic        irq;
  int          fail_count = 0;
  int          num_checks = 0;
  int          n;
  logic [7:0]  ofs [6] = '{IVD_OFS_INT_EN, IVD_OFS_INT_PRI, IVD_OFS_MORE_PRI1, IVD_OFS_MORE_PRI2,
                           IVD_OFS_MORE_EN1, IVD_OFS_MORE_EN2};
  logic [7:0]  val [6] = '{8'h7f, 8'h00, 8'h00, 8'h00, 8'hff, 8'h03};
  ivd_if lnk ();
  ivd_dispatch u_ivd_dispatch (.ref_clk(ref_clk), .arst_n(arst_n), .bus(lnk.dev));
  ivd_core_end u_ivd_core_end (.ref_clk(ref_clk), .arst_n(arst_n), .bus(lnk.core), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .take_en(take_en), .reti(reti),
    .fetch(fetch), .fetch_vector(fetch_vector), .irq(irq));
  ivd_props u_ivd_props (.ref_clk(ref_clk), .arst_n(arst_n), .timer_control_reg(lnk.timer_control_reg),
    .sfr_wr(lnk.sfr_wr), .sfr_rd(lnk.sfr_rd), .sfr_addr(lnk.sfr_addr), .sfr_wdata(lnk.sfr_wdata),
    .sfr_rdata(lnk.sfr_rdata), .irq_req(lnk.irq_req), .irq_vector(lnk.irq_vector), .irq_order(lnk.irq_order),
    .irq_ack(lnk.irq_ack), .ext0_clear(lnk.ext0_clear), .tmr1_clear(lnk.tmr1_clear));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    check(16'(sw_rdata), 16'(exp));
  endtask
  // forwarding and registering may each take a cycle
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  // source flags set and cleared here
  task automatic set_src(input int o, input logic v);
    @(posedge ref_clk);
    case (o)
      0: lnk.timer_control_reg[IVD_EXT0_PEND] <= v;
      1: lnk.timer_control_reg[IVD_TMR0_OVF] <= v;
      2: lnk.timer_control_reg[IVD_EXT1_PEND] <= v;
      3: lnk.timer_control_reg[IVD_TMR1_OVF] <= v;
      4: lnk.uart_control_reg[IVD_UART_TX] <= v;
      5: lnk.timer2_control_reg[IVD_TMR_LO] <= v;
      6: lnk.spi_control_reg[4] <= v;
      7: lnk.smbus_control_reg[IVD_SMB_EV] <= v;
      8: lnk.port_match <= v;
      9: lnk.adc_control_reg[IVD_ADC_WIN] <= v;
      10: lnk.adc_control_reg[IVD_ADC_DONE] <= v;
      11: lnk.pca_control_reg[0] <= v;
      12: lnk.comparator_control_reg[IVD_CMP_RISE] <= v;
      14: lnk.timer3_control_reg[IVD_TMR_LO] <= v;
      15: lnk.touch_sense_control_reg[IVD_TS_DONE] <= v;
      default: lnk.touch_sense_control_reg[IVD_TS_ABOVE] <= v;
    endcase
  endtask
  // peripheral drops flag on clear pulse
  always @(posedge ref_clk) begin
    if (lnk.ext0_clear) lnk.timer_control_reg[IVD_EXT0_PEND] <= 1'b0;
    if (lnk.tmr0_clear) lnk.timer_control_reg[IVD_TMR0_OVF] <= 1'b0;
    if (lnk.ext1_clear) lnk.timer_control_reg[IVD_EXT1_PEND] <= 1'b0;
    if (lnk.tmr1_clear) lnk.timer_control_reg[IVD_TMR1_OVF] <= 1'b0;
  end
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    arst_n = 1'b0;
    {sw_wr, sw_rd, take_en, reti, lnk.port_match} = '0;
    {sw_addr, sw_wdata, lnk.timer_control_reg, lnk.uart_control_reg, lnk.timer2_control_reg} = '0;
    {lnk.timer3_control_reg, lnk.spi_control_reg, lnk.smbus_control_reg, lnk.adc_control_reg} = '0;
    {lnk.pca_control_reg, lnk.comparator_control_reg, lnk.touch_sense_control_reg} = '0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    foreach (ofs[i]) begin
      rdck(ofs[i], 8'h00);
      wr(ofs[i], 8'h5a);
      rdck(ofs[i], 8'h5a);
      wr(ofs[i], val[i]);
    end
    rdck(8'h55, 8'h00);
    $display("test registers done");
    for (int o = 0; o < 17; o++) begin
      if (o == 13)
        continue;
      set_src(o, 1'b1);
      settle();
      check(lnk.irq_vector, 16'h0003 + 16'(o) * 16'h0008);
      check(16'(lnk.irq_order), 16'(o));
      set_src(o, 1'b0);
    end
    settle();
    check(16'(lnk.irq_req), 16'h0000);
    check(lnk.irq_vector, 16'h0000);
    $display("test source table done");
    set_src(16, 1'b1);
    set_src(2, 1'b1);
    settle();
    check(16'(lnk.irq_order), 16'h0002);
    wr(IVD_OFS_MORE_PRI2, 8'h02);
    settle();
    check(16'({lnk.irq_high, lnk.irq_order}), 16'h0030);
    wr(IVD_OFS_INT_PRI, 8'h04);
    settle();
    check(16'({lnk.irq_high, lnk.irq_order}), 16'h0022);
    set_src(16, 1'b0);
    set_src(2, 1'b0);
    $display("test priority done");
    wr(IVD_OFS_MASK, 8'h01);
    take_en <= 1'b1;
    for (int o = 0; o < 4; o++) begin
      set_src(o, 1'b1);
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (fetch !== 1'b1 && n < 20);
      check(16'(n < 20), 16'h0001);
      if (n == 20) close_out();
      check(fetch_vector, 16'h0003 + 16'(o) * 16'h0008);
      settle();
      check(16'(lnk.timer_control_reg), 16'h0000);
      @(posedge ref_clk);
      reti <= 1'b1;
      @(posedge ref_clk);
      reti <= 1'b0;
    end
    take_en <= 1'b0;
    settle();
    check(16'(irq), 16'h0001);
    rdck(IVD_OFS_STAT, 8'h03);
    wr(IVD_OFS_MASK, 8'h00);
    settle();
    check(16'(irq), 16'h0000);
    wr(IVD_OFS_STAT, 8'h03);
    rdck(IVD_OFS_STAT, 8'h00);
    $display("test fetch and status done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
